/* File: hw/dsrb_pkg.sv */
// package of offsets, field positions and constants for the debug state register bank
package dsrb_pkg;
	localparam logic [7:0] addr_tile_cell_osc = 8'h07;
	localparam logic [7:0] addr_tile_wire_osc = 8'h08;
	localparam logic [7:0] addr_periph_cell_osc = 8'h09;
	localparam logic [7:0] addr_periph_wire_osc = 8'h0a;
	localparam logic [7:0] addr_ram_size = 8'h0c;
	localparam logic [7:0] addr_saved_status = 8'h10;
	localparam logic [7:0] addr_saved_pc = 8'h11;
	localparam logic [7:0] addr_saved_sp = 8'h12;
	localparam logic [7:0] addr_read_select = 8'h13;
	localparam logic [7:0] addr_read_regindex = 8'h14;
	localparam logic [7:0] addr_cause = 8'h15;
	localparam logic [7:0] addr_trigger_data = 8'h16;
	localparam logic [7:0] addr_stop_mask = 8'h18;
	localparam logic [7:0] addr_scratch_base = 8'h20;
	localparam logic [7:0] addr_scratch_last = 8'h27;
	localparam logic [31:0] status_rw_mask = 32'h0000_06df;
	localparam logic [31:0] ram_size_mask = 32'hffff_fffc;
	localparam int osc_bits = 16;
	localparam int thread_bits = 8;
	localparam int regidx_bits = 5;
	localparam int cause_lsb = 0;
	localparam int cause_bits = 3;
	localparam int thread_lsb = 8;
	localparam int trig_lsb = 16;
	localparam int trig_bits = 2;
	localparam int sync_stages = 2;
	localparam logic [2:0] cause_none = 3'h0;
	localparam logic [2:0] cause_host = 3'h1;
	localparam logic [2:0] cause_debug_call_instruction = 3'h2;
	localparam logic [2:0] cause_ibreak = 3'h3;
	localparam logic [2:0] cause_dwatch = 3'h4;
	localparam logic [2:0] cause_rwatch = 3'h5;
endpackage

/* File: hw/dsrb_bank.sv */
// debug state register bank of one tile
//
// Contract
// R1 - oscillator counts: 16 bits, kept through reset
// R2 - four counts at consecutive offsets, fixed order
// R3 - read-only ram size, low two bits zero
// R4 - capture saved status word on debug entry
// R5 - status bits 7 fast, 6 paused
// R6 - status bits 4 kernel, 3 irq, 2 eeble
// R7 - status bit 1 irq enable, 0 event enable
// R8 - status bits 10 asid, 9 entry mode, 8 ro
// R9 - capture saved program counter on debug entry
// R10 - capture saved stack pointer on debug entry
// R11 - thread select field feeds thread register read
// R12 - register index field feeds thread register read
// R13 - cause field records debug source, reset zero
// R14 - trigger index, zero for host/call, lowest wins
// R15 - thread field, zero for host requests
// R16 - trigger data: watch address or resource id
// R17 - stop mask holds marked threads outside debug
// R18 - eight shared 32-bit scratch words
// R19 - scratch storage shared with tile config port
// R20 - stop oscillator ten cycles before reading count
// R21 - oscillators asynchronous, separate enables, reset off
// R22 - debug fields writable only in debug mode
// R23 - oscillator counts synchronised before being read
`timescale 1ns/1ps
module dsrb_bank #(
	parameter logic [31:0] ram_size = 32'h0002_0000,
	parameter int threads = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic debug_mode,
	input wire logic ps_wr,
	input wire logic ps_rd,
	input wire logic [7:0] ps_addr,
	input wire logic [31:0] ps_wdata,
	output logic [31:0] ps_rdata,
	input wire logic cfg_wr,
	input wire logic [2:0] cfg_idx,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic osc_core_en,
	input wire logic osc_periph_en,
	input wire logic [15:0] osc_tile_cell_cnt,
	input wire logic [15:0] osc_tile_wire_cnt,
	input wire logic [15:0] osc_periph_cell_cnt,
	input wire logic [15:0] osc_periph_wire_cnt,
	output logic osc_core_run,
	output logic osc_periph_run,
	input wire logic dbg_entry,
	input wire logic [2:0] dbg_cause_in,
	input wire logic [7:0] dbg_thread_in,
	input wire logic [3:0] dbg_trig_hits,
	input wire logic [31:0] dbg_status_in,
	input wire logic [31:0] dbg_pc_in,
	input wire logic [31:0] dbg_sp_in,
	input wire logic [31:0] dbg_data_in,
	output logic [7:0] thread_read_thread,
	output logic [4:0] thread_read_index,
	output logic [7:0] thread_hold
);
	////////////////////////////////////////////////////////////////////////////////
	// oscillator count synchronisers, no reset so the counts survive
	logic [15:0] osc_meta [4];
	logic [15:0] osc_sync [4];
	wire logic [15:0] osc_raw [4];
	assign osc_raw[0] = osc_tile_cell_cnt; // [R2]
	assign osc_raw[1] = osc_tile_wire_cnt; // [R2]
	assign osc_raw[2] = osc_periph_cell_cnt; // [R2]
	assign osc_raw[3] = osc_periph_wire_cnt; // [R2]
	always_ff @(posedge clk_sys) begin
		osc_meta <= osc_raw; // [R23] [R1]
		osc_sync <= osc_meta; // [R23] [R1]
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_core_run <= 1'b0; // [R21]
			osc_periph_run <= 1'b0; // [R21]
		end else begin
			osc_core_run <= osc_core_en; // [R21]
			osc_periph_run <= osc_periph_en; // [R21]
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// register state
	logic [31:0] saved_status_word;
	logic [31:0] saved_program_counter;
	logic [31:0] saved_stack_pointer;
	logic [7:0] read_select;
	logic [4:0] read_regindex;
	logic [2:0] cause;
	logic [7:0] cause_thread;
	logic [1:0] cause_trig;
	logic [31:0] trigger_data;
	logic [7:0] stop_mask;
	logic [31:0] scratch [8];
	////////////////////////////////////////////////////////////////////////////////
	// decode
	wire logic dw = ps_wr && debug_mode; // [R22]
	wire logic wr_status = dw && (ps_addr == dsrb_pkg::addr_saved_status);
	wire logic wr_pc = dw && (ps_addr == dsrb_pkg::addr_saved_pc);
	wire logic wr_sp = dw && (ps_addr == dsrb_pkg::addr_saved_sp);
	wire logic wr_sel = dw && (ps_addr == dsrb_pkg::addr_read_select);
	wire logic wr_idx = dw && (ps_addr == dsrb_pkg::addr_read_regindex);
	wire logic wr_cause = dw && (ps_addr == dsrb_pkg::addr_cause);
	wire logic wr_data = dw && (ps_addr == dsrb_pkg::addr_trigger_data);
	wire logic wr_stop = dw && (ps_addr == dsrb_pkg::addr_stop_mask);
	wire logic in_scratch = (ps_addr >= dsrb_pkg::addr_scratch_base) &&
		(ps_addr <= dsrb_pkg::addr_scratch_last);
	wire logic wr_scr = dw && in_scratch;
	wire logic [2:0] scr_idx = ps_addr[2:0];
	// lowest firing hardware trigger wins
	wire logic [1:0] low_hit = dbg_trig_hits[0] ? 2'h0 : dbg_trig_hits[1] ? 2'h1 :
		dbg_trig_hits[2] ? 2'h2 : dbg_trig_hits[3] ? 2'h3 : 2'h0; // [R14]
	wire logic hw_cause = (dbg_cause_in == dsrb_pkg::cause_ibreak) ||
		(dbg_cause_in == dsrb_pkg::cause_dwatch) ||
		(dbg_cause_in == dsrb_pkg::cause_rwatch);
	wire logic [1:0] next_trig = hw_cause ? low_hit : 2'h0; // [R14]
	wire logic [7:0] next_thread = (dbg_cause_in == dsrb_pkg::cause_host) ?
		8'h00 : dbg_thread_in; // [R15]
	wire logic data_cause = (dbg_cause_in == dsrb_pkg::cause_dwatch) ||
		(dbg_cause_in == dsrb_pkg::cause_rwatch);
	wire logic [31:0] status_ro = saved_status_word & ~dsrb_pkg::status_rw_mask;
	wire logic [31:0] status_wr = (ps_wdata & dsrb_pkg::status_rw_mask) | status_ro;
	////////////////////////////////////////////////////////////////////////////////
	// captured debug state; entry takes priority over a software write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			saved_status_word <= 32'h0;
			saved_program_counter <= 32'h0;
			saved_stack_pointer <= 32'h0;
			cause <= dsrb_pkg::cause_none; // [R13]
			cause_thread <= 8'h00;
			cause_trig <= 2'h0;
			trigger_data <= 32'h0;
		end else if (dbg_entry) begin
			saved_status_word <= {21'h0, dbg_status_in[10:0]} &
				(dsrb_pkg::status_rw_mask | 32'h0000_0100); // [R4] [R5] [R6] [R7] [R8]
			saved_program_counter <= dbg_pc_in; // [R9]
			saved_stack_pointer <= dbg_sp_in; // [R10]
			cause <= dbg_cause_in; // [R13]
			cause_thread <= next_thread; // [R15]
			cause_trig <= next_trig; // [R14]
			if (data_cause) begin
				trigger_data <= dbg_data_in; // [R16]
			end
		end else begin
			if (wr_status) begin
				saved_status_word <= status_wr; // [R8] [R22]
			end
			if (wr_pc) begin
				saved_program_counter <= ps_wdata;
			end
			if (wr_sp) begin
				saved_stack_pointer <= ps_wdata;
			end
			if (wr_cause) begin
				cause <= ps_wdata[dsrb_pkg::cause_lsb +: dsrb_pkg::cause_bits];
				cause_thread <= ps_wdata[dsrb_pkg::thread_lsb +: dsrb_pkg::thread_bits];
				cause_trig <= ps_wdata[dsrb_pkg::trig_lsb +: dsrb_pkg::trig_bits];
			end
			if (wr_data) begin
				trigger_data <= ps_wdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// operands, stop mask and scratch words
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			read_select <= 8'h00;
			read_regindex <= 5'h00;
			stop_mask <= 8'h00;
		end else begin
			if (wr_sel) begin
				read_select <= ps_wdata[7:0]; // [R11]
			end
			if (wr_idx) begin
				read_regindex <= ps_wdata[4:0]; // [R12]
			end
			if (wr_stop) begin
				stop_mask <= ps_wdata[7:0]; // [R17]
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				scratch[i] <= 32'h0;
			end
		end else if (wr_scr) begin
			scratch[scr_idx] <= ps_wdata; // [R18] [R19]
		end else if (cfg_wr) begin
			scratch[cfg_idx] <= cfg_wdata; // [R19]
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// outputs
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		case (ps_addr)
			dsrb_pkg::addr_tile_cell_osc: next_rdata = {16'h0, osc_sync[0]}; // [R1] [R2]
			dsrb_pkg::addr_tile_wire_osc: next_rdata = {16'h0, osc_sync[1]}; // [R1] [R2]
			dsrb_pkg::addr_periph_cell_osc: next_rdata = {16'h0, osc_sync[2]}; // [R2]
			dsrb_pkg::addr_periph_wire_osc: next_rdata = {16'h0, osc_sync[3]}; // [R2]
			dsrb_pkg::addr_ram_size: next_rdata = ram_size & dsrb_pkg::ram_size_mask; // [R3]
			dsrb_pkg::addr_saved_status: next_rdata = saved_status_word;
			dsrb_pkg::addr_saved_pc: next_rdata = saved_program_counter;
			dsrb_pkg::addr_saved_sp: next_rdata = saved_stack_pointer;
			dsrb_pkg::addr_read_select: next_rdata = {24'h0, read_select};
			dsrb_pkg::addr_read_regindex: next_rdata = {27'h0, read_regindex};
			dsrb_pkg::addr_cause: next_rdata = {14'h0, cause_trig, cause_thread, 5'h0, cause};
			dsrb_pkg::addr_trigger_data: next_rdata = trigger_data;
			dsrb_pkg::addr_stop_mask: next_rdata = {24'h0, stop_mask};
			default: next_rdata = in_scratch ? scratch[scr_idx] : 32'h0;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ps_rdata <= 32'h0;
			cfg_rdata <= 32'h0;
			thread_read_thread <= 8'h00;
			thread_read_index <= 5'h00;
			thread_hold <= 8'h00;
		end else begin
			if (ps_rd) begin
				ps_rdata <= next_rdata;
			end
			cfg_rdata <= scratch[cfg_idx]; // [R19]
			thread_read_thread <= read_select; // [R11]
			thread_read_index <= read_regindex; // [R12]
			thread_hold <= debug_mode ? 8'h00 : stop_mask; // [R17]
		end
	end
endmodule // dsrb_bank

/* File: tb/dsrb_bank_sva.sv */
// port checker for the debug state register bank
`timescale 1ns/1ps
module dsrb_bank_chk #(
	parameter logic [31:0] ram_size = 32'h0002_0000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic debug_mode,
	input wire logic ps_wr,
	input wire logic ps_rd,
	input wire logic [7:0] ps_addr,
	input wire logic [31:0] ps_wdata,
	input wire logic [31:0] ps_rdata,
	input wire logic dbg_entry,
	input wire logic [2:0] dbg_cause_in,
	input wire logic [7:0] thread_read_thread,
	input wire logic [7:0] thread_hold
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence wr_rd(a);
		ps_wr && debug_mode && ps_addr == a && !dbg_entry
		##1 ps_rd && ps_addr == a && !ps_wr && !dbg_entry;
	endsequence
	chk_status_write: assert property (wr_rd(8'h10) |=>
		(ps_rdata & 32'hffff_feff) == ($past(ps_wdata, 2) & 32'h0000_06df)) else $error("status bits");
	chk_index_write: assert property (wr_rd(8'h14) |=>
		ps_rdata == ($past(ps_wdata, 2) & 32'h0000_001f)) else $error("index field");
	chk_unmapped_zero: assert property (ps_rd && ps_addr == 8'h0b |=> ps_rdata == 32'h0)
		else $error("unmapped read");
	chk_ram_size: assert property (ps_rd && ps_addr == 8'h0c |=>
		ps_rdata == (ram_size & 32'hffff_fffc)) else $error("ram size");
	chk_host_cause: assert property (dbg_entry && dbg_cause_in == 3'h1
		##1 ps_rd && ps_addr == 8'h15 && !ps_wr |=> ps_rdata[17:0] == 18'h00001) else $error("host");
	chk_select_out: assert property (ps_wr && debug_mode && ps_addr == 8'h13 |=>
		##1 thread_read_thread == 8'($past(ps_wdata, 2))) else $error("thread select");
	chk_stop_hold: assert property (ps_wr && debug_mode && ps_addr == 8'h18
		##1 !debug_mode [*2] |-> thread_hold == 8'($past(ps_wdata, 2))) else $error("stop");
	chk_hold_debug: assert property (debug_mode |=> thread_hold == 8'h00)
		else $error("hold in debug");
	cover property (dbg_entry && dbg_cause_in == 3'h5);
	cover property (ps_wr && !debug_mode);
	cover property (ps_rd && ps_addr == 8'h07);
endmodule // dsrb_bank_chk
bind dsrb_bank dsrb_bank_chk #(.ram_size(ram_size)) u_chk (.clk_sys, .rst_n, .debug_mode, .ps_wr,
	.ps_rd, .ps_addr, .ps_wdata, .ps_rdata, .dbg_entry, .dbg_cause_in, .thread_read_thread,
	.thread_hold);

/* File: tb/dsrb_osc_model.sv */
// ring oscillator model: four counters on a free clock of their own
`timescale 1ns/1ps
module dsrb_osc_model (
	input wire logic core_run,
	input wire logic periph_run,
	output logic [3:0][15:0] cnt
);
	logic ring = 1'b0;
	initial cnt = '0;
	always #37 ring = ~ring; // unrelated to the core clock
	always @(posedge ring) begin
		for (int i = 0; i < 4; i++) begin
			if (i < 2 ? core_run : periph_run) begin // separate enables, still when off
				cnt[i] <= cnt[i] + 16'(2 * i + 1);
			end
		end
	end
endmodule // dsrb_osc_model

/* File: tb/dsrb_bank_test.sv */
// self-checking bench for the debug state register bank
`timescale 1ns/1ps
module dsrb_bank_test;
	logic clk_sys = 1'b0, rst_n = 1'b0, debug_mode = 1'b1, ps_wr = 1'b0, ps_rd = 1'b0;
	logic cfg_wr = 1'b0, dbg_entry = 1'b0, osc_core_en = 1'b0, osc_periph_en = 1'b0;
	logic [7:0] ps_addr = 8'h00, thread_in = 8'h00, rd_thread, hold;
	logic [2:0] cfg_idx = 3'h0, dbg_cause_in = 3'h0;
	logic [3:0] hits = 4'h0;
	logic [4:0] rd_index;
	logic [31:0] ps_wdata = '0, cfg_wdata = '0, data_in = '0, ps_rdata, cfg_rdata, v;
	logic [3:0][15:0] cnt;
	logic core_run, periph_run;
	int errors = 0, samples_checked = 0;
	logic [71:0] rows [11] = '{{8'h10, 32'hffff_ffff, 32'h0000_06df},
		{8'h11, 32'h1234_5678, 32'h1234_5678}, {8'h12, 32'ha5a5_a5a5, 32'ha5a5_a5a5},
		{8'h13, 32'hffff_ff7e, 32'h0000_007e}, {8'h14, 32'hffff_fff1, 32'h0000_0011},
		{8'h15, 32'hffff_ffff, 32'h0003_ff07}, {8'h16, 32'h0f0f_0f0f, 32'h0f0f_0f0f},
		{8'h18, 32'hffff_ffff, 32'h0000_00ff}, {8'h0c, 32'hffff_ffff, 32'h0001_2344},
		{8'h0b, 32'hffff_ffff, 32'h0000_0000}, {8'h27, 32'h0123_4567, 32'h0123_4567}};
	always #50 clk_sys = ~clk_sys;
	dsrb_osc_model u_osc (.core_run(core_run), .periph_run(periph_run), .cnt(cnt));
	dsrb_bank #(.ram_size(32'h0001_2347)) u_dut (.clk_sys, .rst_n, .debug_mode, .ps_wr,
		.ps_rd, .ps_addr, .ps_wdata, .ps_rdata, .cfg_wr, .cfg_idx, .cfg_wdata, .cfg_rdata,
		.osc_core_en, .osc_periph_en, .osc_tile_cell_cnt(cnt[0]), .osc_tile_wire_cnt(cnt[1]),
		.osc_periph_cell_cnt(cnt[2]), .osc_periph_wire_cnt(cnt[3]), .osc_core_run(core_run),
		.osc_periph_run(periph_run), .dbg_entry, .dbg_cause_in, .dbg_thread_in(thread_in),
		.dbg_trig_hits(hits), .dbg_status_in(data_in), .dbg_pc_in(~data_in),
		.dbg_sp_in({data_in[15:0], data_in[31:16]}), .dbg_data_in(data_in),
		.thread_read_thread(rd_thread), .thread_read_index(rd_index), .thread_hold(hold));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ps_wr <= 1'b1;
		ps_addr <= a;
		ps_wdata <= d;
		@(posedge clk_sys);
		ps_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ps_rd <= 1'b1;
		ps_addr <= a;
		@(posedge clk_sys);
		ps_rd <= 1'b0;
		@(posedge clk_sys);
		d = ps_rdata;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h15, v);
		chk(v, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i][71:64], rows[i][63:32]);
			rd(rows[i][71:64], v);
			chk(v, rows[i][31:0]);
		end
		chk(32'({rd_index, rd_thread}), 32'h0000_117e);
		$display("test table done");
		wr(8'h18, 32'h0000_00a5);
		debug_mode <= 1'b0;
		wr(8'h11, 32'h0);
		rd(8'h11, v);
		chk(v, 32'h1234_5678);
		chk(32'(hold), 32'h0000_00a5);
		$display("test refusal done");
		debug_mode <= 1'b1;
		thread_in <= 8'h05;
		hits <= 4'b1010;
		for (int c = 1; c < 6; c++) begin
			data_in <= 32'h5a5a_07a0 + 32'(c);
			dbg_entry <= 1'b1;
			dbg_cause_in <= 3'(c);
			@(posedge clk_sys);
			dbg_entry <= 1'b0;
			rd(8'h15, v);
			chk(v, {14'h0, c > 2 ? 2'h1 : 2'h0, c == 1 ? 8'h00 : 8'h05, 5'h0, 3'(c)});
		end
		rd(8'h16, v);
		chk(v, 32'h5a5a_07a5);
		rd(8'h10, v);
		chk(v, 32'h0000_0785);
		rd(8'h11, v);
		chk(v, ~data_in);
		rd(8'h12, v);
		chk(v, {data_in[15:0], data_in[31:16]});
		$display("test capture done");
		cfg_wr <= 1'b1;
		cfg_idx <= 3'h3;
		cfg_wdata <= 32'h0bad_cafe;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		cfg_idx <= 3'h7;
		rd(8'h23, v);
		chk(v, 32'h0bad_cafe);
		chk(cfg_rdata, 32'h0123_4567);
		osc_core_en <= 1'b1;
		osc_periph_en <= 1'b1;
		repeat (40) @(posedge clk_sys);
		chk(32'({core_run, periph_run}), 32'h3);
		osc_core_en <= 1'b0;
		osc_periph_en <= 1'b0;
		repeat (10) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			rd(8'h07 + 8'(i), v);
			chk(v, {16'h0, cnt[i]});
		end
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h0a, v);
		chk(v, {16'h0, cnt[3]});
		$display("test oscillator done");
		finish_test();
	end
endmodule // dsrb_bank_test
